//--- design/system_clock_and_power_modes.sv
// System clock source selection and CPU-off power modes.
// Assumes halt_req and wake_req are one-cycle pulses from the CPU core.
`timescale 1ns/1ps
module system_clock_and_power_modes
  import clock_power_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = FAST_SETTLE_CYCLES,
  parameter int unsigned FAST_PERIOD = FAST_TICK_CYCLES,
  parameter int unsigned SLOW_PERIOD = SLOW_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  output logic cpu_run,
  output logic cpu_system_clock,
  output logic high_speed_clock,
  output logic subsidiary_clock,
  output logic slow_osc_clock,
  output logic [2:0] power_mode,
  output logic slow_mode
);

  // Register state
  logic [2:0] clock_select_field_q;
  logic fast_keep_in_halt_q;
  logic slow_keep_in_halt_q;
  logic fast_osc_enable_q;
  power_mode_t mode_q;
  power_mode_t mode_d;
  logic [PRESCALE_W-1:0] prescale_q;
  logic fast_run_q;

  // Bus decode
  logic hit_sys;
  logic hit_fast;
  logic wr_sys;
  logic wr_fast;
  logic [DATA_W-1:0] sys_read;
  logic [DATA_W-1:0] fast_read;
  logic [DATA_W-1:0] read_mux;

  // Clock plumbing
  logic sel_sub;
  logic fast_run;
  logic sub_run;
  logic slow_run;
  logic sys_run;
  logic fast_raw;
  logic slow_raw;
  logic fast_osc_stable_flag;
  logic fast_restart;
  logic [PRESCALE_W:0] tap;
  logic fast_div_tick;
  logic sub_tick;
  logic sys_tick;

  assign hit_sys = (reg_addr == SYS_CLK_CTRL_ADDR);
  assign hit_fast = (reg_addr == FAST_OSC_CTRL_ADDR);
  assign wr_sys = reg_write && hit_sys;
  assign wr_fast = reg_write && hit_fast;

  assign sys_read = {clock_select_field_q, 3'h0,
                     fast_keep_in_halt_q, slow_keep_in_halt_q};
  assign fast_read = {6'h00, fast_osc_stable_flag, fast_osc_enable_q};
  assign read_mux = hit_sys ? sys_read :
                    hit_fast ? fast_read : '0;

  // Control registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clock_select_field_q <= CLK_SEL_RESET;
      fast_keep_in_halt_q <= FAST_KEEP_RESET;
      slow_keep_in_halt_q <= SLOW_KEEP_RESET;
    end else if (wr_sys) begin
      clock_select_field_q <=
        reg_wdata[CLK_SEL_LSB +: CLK_SEL_W];
      fast_keep_in_halt_q <= reg_wdata[FAST_KEEP_BIT];
      slow_keep_in_halt_q <= reg_wdata[SLOW_KEEP_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fast_osc_enable_q <= FAST_EN_RESET;
    end else if (wr_fast) begin
      fast_osc_enable_q <= reg_wdata[FAST_EN_BIT];
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Power state: halt picks the mode from the keep bits
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PM_RUN: begin
        if (halt_req) begin
          case ({fast_keep_in_halt_q, slow_keep_in_halt_q})
            2'b00: mode_d = PM_SLEEP;
            2'b01: mode_d = PM_CPU_OFF_SLOW_ONLY_MODE;
            2'b11: mode_d = PM_CPU_OFF_BOTH_CLOCKS_MODE;
            2'b10: mode_d = PM_CPU_OFF_FAST_ONLY_MODE;
            default: mode_d = PM_RUN;
          endcase
        end
      end
      PM_CPU_OFF_SLOW_ONLY_MODE, PM_CPU_OFF_BOTH_CLOCKS_MODE, PM_CPU_OFF_FAST_ONLY_MODE, PM_SLEEP: begin
        if (wake_req) begin
          mode_d = PM_RUN;
        end
      end
      default: mode_d = PM_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= PM_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign sel_sub = (clock_select_field_q == CLK_SEL_SUB);

  // Fast oscillator: always on in fast mode, per enable in slow mode,
  // kept in the two idle modes that ask for it
  always_comb begin
    case (mode_q)
      PM_RUN: fast_run = !sel_sub || fast_osc_enable_q;
      PM_CPU_OFF_BOTH_CLOCKS_MODE: fast_run = 1'b1;
      PM_CPU_OFF_FAST_ONLY_MODE: fast_run = 1'b1;
      PM_CPU_OFF_SLOW_ONLY_MODE: fast_run = 1'b0;
      PM_SLEEP: fast_run = 1'b0;
      default: fast_run = 1'b0;
    endcase
  end

  // Subsidiary clock to peripherals
  always_comb begin
    case (mode_q)
      PM_RUN: sub_run = 1'b1;
      PM_CPU_OFF_SLOW_ONLY_MODE: sub_run = 1'b1;
      PM_CPU_OFF_BOTH_CLOCKS_MODE: sub_run = 1'b1;
      PM_CPU_OFF_FAST_ONLY_MODE: sub_run = 1'b0;
      PM_SLEEP: sub_run = 1'b0;
      default: sub_run = 1'b0;
    endcase
  end

  // Slow oscillator survives sleep only for the watchdog
  assign slow_run = (mode_q != PM_SLEEP) || wdt_enable;

  // System clock keeps going in idle when its source stays up
  always_comb begin
    case (mode_q)
      PM_RUN: sys_run = 1'b1;
      PM_CPU_OFF_SLOW_ONLY_MODE: sys_run = sel_sub;
      PM_CPU_OFF_BOTH_CLOCKS_MODE: sys_run = 1'b1;
      PM_CPU_OFF_FAST_ONLY_MODE: sys_run = !sel_sub;
      PM_SLEEP: sys_run = 1'b0;
      default: sys_run = 1'b0;
    endcase
  end

  // Restart settling when the oscillator is switched on again or
  // software writes the enable high
  assign fast_restart = (fast_run && !fast_run_q) ||
                        (wr_fast && reg_wdata[FAST_EN_BIT]);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fast_run_q <= 1'b0;
    end else begin
      fast_run_q <= fast_run;
    end
  end

  osc_tick #(
    .PERIOD(FAST_PERIOD)
  ) u_fast_rc_oscillator (
    .clock(clock),
    .rst_b(rst_b),
    .run(fast_run),
    .tick(fast_raw)
  );

  osc_tick #(
    .PERIOD(SLOW_PERIOD)
  ) u_slow_rc_oscillator (
    .clock(clock),
    .rst_b(rst_b),
    .run(slow_run),
    .tick(slow_raw)
  );

  osc_settle #(
    .SETTLE(SETTLE_CYCLES)
  ) u_fast_settle (
    .clock(clock),
    .rst_b(rst_b),
    .run(fast_run),
    .restart(fast_restart),
    .stable(fast_osc_stable_flag)
  );

  // Prescaler counts fast ticks; divide-by-2^i taps fire on wrap
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q <= '0;
    end else if (!fast_run) begin
      prescale_q <= '0;
    end else if (fast_raw) begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  assign tap[0] = fast_raw;
  genvar i;
  generate
    for (i = 1; i <= PRESCALE_W; i++) begin : g_tap
      assign tap[i] = fast_raw && (prescale_q[i-1:0] == '0);
    end
  endgenerate

  // Code 111 has no tap; unstable fast clock is held back from the CPU
  assign fast_div_tick = sel_sub ? 1'b0 :
    tap[clock_select_field_q] && fast_osc_stable_flag;
  assign sub_tick = slow_raw && sub_run;
  assign sys_tick = sys_run &&
    (sel_sub ? sub_tick : fast_div_tick);

  // Registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpu_run <= 1'b1;
      cpu_system_clock <= 1'b0;
      high_speed_clock <= 1'b0;
      subsidiary_clock <= 1'b0;
      slow_osc_clock <= 1'b0;
      power_mode <= PM_RUN;
      slow_mode <= 1'b0;
    end else begin
      // Follows the next mode so halt and wake both act in one cycle
      cpu_run <= (mode_d == PM_RUN);
      cpu_system_clock <= sys_tick;
      high_speed_clock <= fast_raw;
      subsidiary_clock <= sub_tick;
      slow_osc_clock <= slow_raw;
      power_mode <= mode_d;
      slow_mode <= sel_sub;
    end
  end

endmodule

//--- design/clock_power_pkg.sv
// Constants for the system clock and power-mode block.
// Assumes a single 100 MHz clock; oscillators are modelled as tick enables.
package clock_power_pkg;

  // Core clock and the two internal oscillators, in Hz
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned FAST_OSC_HZ = 8_000_000;
  localparam int unsigned SLOW_OSC_HZ = 32_000;

  // Oscillator periods in core cycles, rounded down, at least one
  localparam int unsigned FAST_TICK_CYCLES = CLOCK_HZ / FAST_OSC_HZ;
  localparam int unsigned SLOW_TICK_CYCLES = CLOCK_HZ / SLOW_OSC_HZ;

  // Fast oscillator settling time, rounded up to whole cycles
  localparam int unsigned FAST_SETTLE_NS = 10_000;
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned FAST_SETTLE_CYCLES =
    (FAST_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] SYS_CLK_CTRL_ADDR = 8'h00;
  localparam logic [7:0] FAST_OSC_CTRL_ADDR = 8'h01;

  // System clock control fields
  localparam int unsigned CLK_SEL_LSB = 5;
  localparam int unsigned CLK_SEL_W = 3;
  localparam int unsigned FAST_KEEP_BIT = 1;
  localparam int unsigned SLOW_KEEP_BIT = 0;
  localparam logic [2:0] CLK_SEL_SUB = 3'h7;
  localparam logic [2:0] CLK_SEL_RESET = 3'h0;
  localparam logic FAST_KEEP_RESET = 1'b0;
  localparam logic SLOW_KEEP_RESET = 1'b0;

  // Fast oscillator control fields
  localparam int unsigned FAST_STABLE_BIT = 1;
  localparam int unsigned FAST_EN_BIT = 0;
  localparam logic FAST_EN_RESET = 1'b1;

  // Prescaler for the fast clock, divide by 1 to 64
  localparam int unsigned PRESCALE_W = 6;

  // Power state, Gray coded along run -> idle -> sleep
  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_CPU_OFF_SLOW_ONLY_MODE = 3'h1,
    PM_CPU_OFF_BOTH_CLOCKS_MODE = 3'h3,
    PM_CPU_OFF_FAST_ONLY_MODE = 3'h2,
    PM_SLEEP = 3'h6
  } power_mode_t;

endpackage

//--- design/osc_tick.sv
// Tick generator standing in for one free-running RC oscillator.
// Assumes the core clock is much faster than the modelled oscillator.
`timescale 1ns/1ps
module osc_tick
  import clock_power_pkg::*;
#(
  parameter int unsigned PERIOD = FAST_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  output logic tick
);

  localparam int unsigned CNT_W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic wrap;

  assign wrap = (count_q == LAST);
  assign count_d = wrap ? '0 : count_q + 1'b1;

  // A stopped oscillator restarts from a fresh phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      count_q <= '0;
      tick <= 1'b0;
    end else begin
      count_q <= count_d;
      tick <= wrap;
    end
  end

endmodule

//--- design/osc_settle.sv
// Settling timer for the fast oscillator; raises stable after a delay.
// Assumes restart is a one-cycle pulse from the owning block.
`timescale 1ns/1ps
module osc_settle
  import clock_power_pkg::*;
#(
  parameter int unsigned SETTLE = FAST_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic restart,
  output logic stable
);

  localparam int unsigned CNT_W = $clog2(SETTLE + 1);
  localparam logic [CNT_W-1:0] DONE = CNT_W'(SETTLE);

  logic [CNT_W-1:0] count_q;
  logic reached;

  assign reached = (count_q == DONE);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      stable <= 1'b0;
    end else if (!run || restart) begin
      count_q <= '0;
      stable <= 1'b0;
    end else if (!reached) begin
      count_q <= count_q + 1'b1;
      stable <= 1'b0;
    end else begin
      stable <= 1'b1;
    end
  end

endmodule

//--- verification/clock_power_props.sv
// Port checker for the clock and power-mode block.
// Assumes the sim parameters: fast tick every 12 cycles.
`timescale 1ns/1ps
module clock_power_props
  import clock_power_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  input wire logic cpu_run,
  input wire logic cpu_system_clock,
  input wire logic high_speed_clock,
  input wire logic subsidiary_clock,
  input wire logic slow_osc_clock,
  input wire logic [2:0] power_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Stable mode: a tick launched on the entry edge is not judged
  chk_halt_stop: assert property (halt_req && power_mode == PM_RUN
    |=> !cpu_run && power_mode != PM_RUN) else $error("halt ignored");
  chk_wake_run: assert property (wake_req && power_mode != PM_RUN
    |=> cpu_run && power_mode == PM_RUN) else $error("wake ignored");
  chk_off_stop: assert property (power_mode != PM_RUN |-> !cpu_run)
    else $error("cpu runs while off");
  chk_sleep_quiet: assert property ($stable(power_mode)
    && power_mode == PM_SLEEP |-> !subsidiary_clock && !cpu_system_clock)
    else $error("tick in sleep");
  // Raw oscillator ticks lag the mode by two registers
  chk_sleep_wdt: assert property ($stable(power_mode)
    && $past(power_mode, 2) == PM_SLEEP && !$past(wdt_enable, 2)
    |-> !slow_osc_clock)
    else $error("slow osc in sleep");
  chk_cpu_off_slow_only_mode_fast: assert property ($stable(power_mode)
    && $past(power_mode, 2) == PM_CPU_OFF_SLOW_ONLY_MODE |-> !high_speed_clock)
    else $error("fast tick in cpu_off_slow_only_mode");
  chk_cpu_off_fast_only_mode_sub: assert property ($stable(power_mode)
    && power_mode == PM_CPU_OFF_FAST_ONLY_MODE |-> !subsidiary_clock)
    else $error("sub tick in cpu_off_fast_only_mode");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 0)
    else $error("read data without read");
  chk_fast_gap: assert property (high_speed_clock
    |=> !high_speed_clock [*8]) else $error("fast ticks too close");
endmodule

bind system_clock_and_power_modes clock_power_props clock_power_props_i (
  .clock, .rst_b, .reg_read, .reg_rdata, .halt_req, .wake_req, .wdt_enable,
  .cpu_run, .cpu_system_clock, .high_speed_clock, .subsidiary_clock,
  .slow_osc_clock, .power_mode);

//--- verification/testbench.sv
// Self-checking bench for the clock and power-mode block.
// Assumes shortened settle and slow periods set at the instance.
`timescale 1ns/1ps
module testbench;
  import clock_power_pkg::*;
  localparam int FP = 12;
  localparam int SP = 10;
  logic clock = 0;
  logic rst_b = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic reg_write = 0, reg_read = 0, halt_req = 0, wake_req = 0;
  logic wdt_enable = 0;
  logic cpu_run, sys_t, hs_t, sub_t, sl_t, slow_mode;
  logic [2:0] power_mode;
  int err_count = 0, total_checks = 0, ch, cs, cl, cy;
  power_mode_t pm [4] = '{PM_SLEEP, PM_CPU_OFF_SLOW_ONLY_MODE, PM_CPU_OFF_FAST_ONLY_MODE, PM_CPU_OFF_BOTH_CLOCKS_MODE};
  always #5 clock = ~clock;
  system_clock_and_power_modes #(.SETTLE_CYCLES(8), .FAST_PERIOD(FP),
    .SLOW_PERIOD(SP)) system_clock_and_power_modes_i (.clock(clock),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
    .cpu_run(cpu_run), .cpu_system_clock(sys_t), .high_speed_clock(hs_t),
    .subsidiary_clock(sub_t), .slow_osc_clock(sl_t),
    .power_mode(power_mode), .slow_mode(slow_mode));
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Tasks start just after an edge and drive by NBA
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge clock);
  endtask
  task automatic count(int n);
    ch = 0;
    cs = 0;
    cl = 0;
    cy = 0;
    repeat (n) begin
      @(posedge clock) #1;
      ch += hs_t;
      cs += sub_t;
      cl += sl_t;
      cy += sys_t;
    end
  endtask
  task automatic wait_tick();
    int i;
    for (i = 0; i < 5000 && sys_t !== 1'b1; i++) @(posedge clock) #1;
    if (i == 5000) begin
      err_count++;
      final_report();
    end
  endtask
  initial begin
    int g, k;
    logic [7:0] a;
    longint t0;
    void'($urandom(82268));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h01);
    repeat (20) @(posedge clock);
    rd(8'h01, 8'h03);
    a = 8'($urandom_range(255, 2));
    wr(a, 8'hff);
    rd(a, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'he3);
    wr(8'h01, 8'hff);
    @(posedge clock);
    rd(8'h01, 8'h01);
    repeat (20) @(posedge clock);
    $display("registers done");
    for (k = 0; k < 8; k++) begin
      wr(8'h00, 8'(k << 5));
      wait_tick();
      @(posedge clock) #1;
      wait_tick();
      t0 = $time;
      @(posedge clock) #1;
      wait_tick();
      g = int'(($time - t0) / 10);
      check(16'(g), 16'(k == 7 ? SP : FP << k));
      check(slow_mode, k == 7);
    end
    $display("divider done");
    wr(8'h01, 8'h00);
    repeat (2) @(posedge clock);
    count(60);
    check(ch > 0, 1'b0);
    check(cs > 0 && cy > 0, 1'b1);
    wr(8'h01, 8'h01);
    repeat (20) @(posedge clock);
    count(60);
    check(ch > 0, 1'b1);
    wr(8'h00, 8'h00);
    wake_req <= 1'b1;
    @(posedge clock);
    wake_req <= 1'b0;
    #1 check(cpu_run, 1'b1);
    $display("slow mode done");
    for (k = 0; k < 4; k++) begin
      wdt_enable <= 1'($urandom);
      wr(8'h00, 8'(k));
      repeat (20) @(posedge clock);
      halt_req <= 1'b1;
      @(posedge clock);
      halt_req <= 1'b0;
      #1 check(power_mode, pm[k]);
      check(cpu_run, 1'b0);
      repeat (2) @(posedge clock);
      count(60);
      check({ch > 0, cs > 0, cl > 0, cy > 0},
        {k[1], k[0], k != 0 || wdt_enable, k[1]});
      wake_req <= 1'b1;
      @(posedge clock);
      wake_req <= 1'b0;
      #1 check(power_mode, PM_RUN);
      check(cpu_run, 1'b1);
    end
    $display("halt modes done");
    final_report();
  end
endmodule
